/* File: logic/bsd_store.sv */
/*
  Decode and execute of the register-plus-displacement byte field store.
  Holds the opcode recognition, the displacement fetch, the bit address sum,
  the single eight-bit field write request, the status hold level and the done pulse.
  Assumes a fetch stream that holds each word until fetch_take_out pulses, a
  register file read port whose data is valid by the calculation cycle, and a
  field write path that performs the read-modify-write of one or two words,
  touches nothing else and holds write_ready_in low while busy.
*/
`timescale 1ns/1ps
module bsd_store
  import bsd_pkg::*;
#(
  parameter int WORD_W = BSD_WORD_W,
  parameter int REG_W = BSD_REG_W,
  parameter int FIELD_W = BSD_FIELD_W,
  parameter int OP_WORDS = BSD_OP_WORDS
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [BSD_WORD_W-1:0] fetch_word_in,
  input wire logic fetch_valid_in,
  output logic fetch_take_out,
  output logic op_match_out,
  output bsd_rsel_t reg_sel_out,
  input wire logic [BSD_REG_W-1:0] src_data_in,
  input wire logic [BSD_REG_W-1:0] base_data_in,
  output logic write_valid_out,
  output bsd_fwrite_t write_out,
  input wire logic write_ready_in,
  output logic status_hold_out,
  output logic done_out
);
  typedef enum logic [3:0] {
    BSD_IDLE = 4'h1,
    BSD_DISP = 4'h2,
    BSD_CALC = 4'h4,
    BSD_WRITE = 4'h8
  } bsd_state_t;

  // Width of the count of words taken for one operation
  localparam int CNT_W = $clog2(OP_WORDS + 1);

  bsd_state_t state_reg;
  bsd_state_t state_next;
  logic [WORD_W-1:0] disp_reg;
  logic [CNT_W-1:0] word_cnt_reg;
  logic [REG_W-1:0] disp_ext;

  function automatic logic is_field_store(input logic [BSD_WORD_W-1:0] w);
    return w[BSD_OPC_HI:BSD_OPC_LO] == BSD_OPC_CODE;
  endfunction

  // Register fields of the opcode word
  function automatic bsd_rsel_t decode_rsel(input logic [BSD_WORD_W-1:0] w);
    bsd_rsel_t r;
    r = '0;
    r.file_sel = w[BSD_FILE_BIT];
    r.src_sel = w[BSD_SRC_HI:BSD_SRC_LO];
    r.base_sel = w[BSD_BASE_HI:BSD_BASE_LO];
    return r;
  endfunction

  // Take pulse high masks a second take of the same word
  wire logic take_opcode = state_reg == BSD_IDLE && fetch_valid_in && !fetch_take_out &&
                           is_field_store(fetch_word_in);
  wire logic take_disp = state_reg == BSD_DISP && fetch_valid_in && !fetch_take_out &&
                         word_cnt_reg < CNT_W'(OP_WORDS);
  wire logic write_done = state_reg == BSD_WRITE && write_ready_in;

  // Sequencing: opcode, displacement, address, field write
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BSD_IDLE: begin
        if (take_opcode) begin
          state_next = BSD_DISP;
        end
      end
      BSD_DISP: begin
        if (take_disp) begin
          state_next = BSD_CALC;
        end
      end
      BSD_CALC: begin
        state_next = BSD_WRITE;
      end
      BSD_WRITE: begin
        if (write_ready_in) begin
          state_next = BSD_IDLE;
        end
      end
      default: begin
        state_next = BSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= BSD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Words of the current operation: opcode, then one displacement
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_cnt_reg <= '0;
    end else if (take_opcode) begin
      word_cnt_reg <= CNT_W'(1);
    end else if (take_disp) begin
      word_cnt_reg <= word_cnt_reg + CNT_W'(1);
    end else if (write_done) begin
      word_cnt_reg <= '0;
    end
  end

  // One-cycle take pulse for each of the two words
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fetch_take_out <= 1'b0;
      op_match_out <= 1'b0;
    end else begin
      fetch_take_out <= take_opcode || take_disp;
      op_match_out <= take_opcode;
    end
  end

  // Shared file select bit drives both register fields
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_sel_out <= '0;
    end else if (take_opcode) begin
      reg_sel_out <= decode_rsel(fetch_word_in);
    end
  end

  // Displacement word kept for the address sum

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      disp_reg <= '0;
    end else if (take_disp) begin
      disp_reg <= fetch_word_in;
    end
  end

  // Sign extension of the displacement, one bit at a time
  for (genvar i = 0; i < REG_W; i++) begin : g_sext
    if (i < WORD_W) begin : g_low
      assign disp_ext[i] = disp_reg[i];
    end else begin : g_high
      assign disp_ext[i] = disp_reg[WORD_W-1];
    end
  end

  // Bit-granular address, wraps modulo the register width
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_out.bit_addr <= '0;
    end else if (state_reg == BSD_CALC) begin
      write_out.bit_addr <= base_data_in + disp_ext;
    end
  end

  // Upper source bits are ignored
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_out.data <= '0;
    end else if (state_reg == BSD_CALC) begin
      write_out.data <= src_data_in[FIELD_W-1:0];
    end
  end

  // Exactly one eight-bit field write; straddling handled by the write path
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_valid_out <= 1'b0;
    end else if (state_reg == BSD_CALC) begin
      write_valid_out <= 1'b1;
    end else if (write_valid_out && write_ready_in) begin
      write_valid_out <= 1'b0;
    end
  end

  // Done pulse on the edge the write is accepted
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= write_done;
    end
  end

  // Status flags frozen for the whole operation
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_hold_out <= 1'b0;
    end else begin
      status_hold_out <= state_reg != BSD_IDLE || take_opcode;
    end
  end
endmodule

/* File: logic/bsd_pkg.sv */
/*
  Constants and carrier types for the byte field store decoder.
  Assumes a 16-bit instruction stream and a 32-bit register file of two banks.

// What this block does
// - An opcode word whose bits 15 to 9 are 1010110 is recognised, its low bits giving source, file select and base.
// - The operation is two words long, the word after the opcode being taken as displacement before moving on.
// - The destination is a bit address, so the byte may start at any bit position.
// - The stored byte is the low eight bits of the source register.
// - The store is an eight-bit field write that may straddle two memory words.
*/
package bsd_pkg;
  localparam int BSD_WORD_W = 16;
  localparam int BSD_REG_W = 32;
  localparam int BSD_REGSEL_W = 4;
  localparam int BSD_OPC_HI = 15;
  localparam int BSD_OPC_LO = 9;
  localparam logic [6:0] BSD_OPC_CODE = 7'h56;
  localparam int BSD_SRC_HI = 8;
  localparam int BSD_SRC_LO = 5;
  localparam int BSD_FILE_BIT = 4;
  localparam int BSD_BASE_HI = 3;
  localparam int BSD_BASE_LO = 0;
  localparam int BSD_FIELD_W = 8;
  localparam int BSD_OP_WORDS = 2;

  typedef struct packed {
    logic file_sel;
    logic [BSD_REGSEL_W-1:0] src_sel;
    logic [BSD_REGSEL_W-1:0] base_sel;
  } bsd_rsel_t;

  typedef struct packed {
    logic [BSD_REG_W-1:0] bit_addr;
    logic [BSD_FIELD_W-1:0] data;
  } bsd_fwrite_t;
endpackage

/* File: tb/bsd_chk_sva.sv */
/* Port checker for bsd_store; expects the bind below. */
`timescale 1ns/1ps
module bsd_chk import bsd_pkg::*; (input wire logic clk_in, rst_in, fetch_valid_in, fetch_take_out,
  input wire logic op_match_out, write_valid_out, write_ready_in, status_hold_out, done_out,
  input wire logic [15:0] fetch_word_in, input wire logic [31:0] src_data_in, base_data_in,
  input wire bsd_rsel_t reg_sel_out, input wire bsd_fwrite_t write_out);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_opc_match: assert property (op_match_out |-> $past(fetch_word_in[15:9]) == BSD_OPC_CODE)
    else $error("opc");
  a_disp_take: assert property (op_match_out ##1 fetch_valid_in |-> ##1 fetch_take_out) else $error("disp");
  a_take_pulse: assert property (fetch_take_out |=> !fetch_take_out) else $error("take pulse");
  a_done_after: assert property (done_out |-> !write_valid_out) else $error("one write");
  a_addr_sum: assert property ($rose(write_valid_out) |-> write_out.bit_addr == $past(base_data_in) +
    {{16{$past(fetch_word_in[15], 2)}}, $past(fetch_word_in, 2)}) else $error("addr");
  a_low_byte: assert property ($rose(write_valid_out) |-> write_out.data == $past(src_data_in[7:0]))
    else $error("byte");
  a_write_hold: assert property (write_valid_out && !write_ready_in |=> write_valid_out && $stable(write_out))
    else $error("hold");
  a_write_end: assert property (write_valid_out && write_ready_in |=> done_out && !write_valid_out)
    else $error("end");
  a_flags_kept: assert property (write_valid_out |-> status_hold_out) else $error("flags");
  cover property (done_out);
  cover property (write_valid_out && !write_ready_in);
  cover property (op_match_out);
endmodule
bind bsd_store bsd_chk CHK (.*);

/* File: tb/bsd_wp_model.sv */
/* Field write path stand-in, ready stall_in+1 cycles after write_valid_in rises; driven by tb_top. */
`timescale 1ns/1ps
module bsd_wp_model (input wire logic clk_in, write_valid_in, input wire logic [3:0] stall_in,
  output logic write_ready_out = 1'b0);
  logic [3:0] wait_reg = 4'h0;
  always @(posedge clk_in) begin
    wait_reg <= (write_valid_in && !write_ready_out) ? wait_reg + 4'h1 : 4'h0;
    write_ready_out <= write_valid_in && !write_ready_out && wait_reg >= stall_in;
  end
endmodule

/* File: tb/tb_top.sv */
/* Bench for bsd_store; assumes the bound checker and write path model. */
`timescale 1ns/1ps
module tb_top import bsd_pkg::*;;
  logic clk_in = 0, rst_in = 1, fetch_valid_in = 0, write_ready_in, fetch_take_out, op_match_out;
  logic write_valid_out, status_hold_out, done_out;
  logic [15:0] fetch_word_in = 16'h0;
  logic [31:0] src_data_in = 32'hffffffef, base_data_in = 32'h0;
  logic [3:0] stall = 4'h0;
  bsd_rsel_t reg_sel_out;
  bsd_fwrite_t write_out;
  int fail_count = 0, samples_checked = 0;
  bsd_store DUT (.clk_in(clk_in), .rst_in(rst_in), .fetch_word_in(fetch_word_in), .fetch_valid_in(fetch_valid_in),
    .fetch_take_out(fetch_take_out), .op_match_out(op_match_out), .reg_sel_out(reg_sel_out),
    .src_data_in(src_data_in), .base_data_in(base_data_in), .write_valid_out(write_valid_out),
    .write_out(write_out), .write_ready_in(write_ready_in), .status_hold_out(status_hold_out),
    .done_out(done_out));
  bsd_wp_model PM (.clk_in, .write_valid_in(write_valid_out), .stall_in(stall), .write_ready_out(write_ready_in));
  initial forever #50 clk_in = ~clk_in;
  task automatic check(string s, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic store(logic [15:0] disp, logic [31:0] base, logic [31:0] addr);
    int n = 0;
    base_data_in = base;
    fetch_word_in = 16'hac31;
    fetch_valid_in = 1'b1;
    @(negedge clk_in);
    while (!fetch_take_out && n++ < 20) @(negedge clk_in);
    check("select", 32'h111, 32'(reg_sel_out));
    check("match", 32'h1, 32'(op_match_out));
    fetch_word_in = disp;
    @(negedge clk_in);
    while (!fetch_take_out && n++ < 40) @(negedge clk_in);
    check("disp match", 32'h0, 32'(op_match_out));
    fetch_valid_in = 1'b0;
    fetch_word_in = ~disp;
    while (!write_valid_out && n++ < 60) @(negedge clk_in);
    check("address", addr, write_out.bit_addr);
    check("data", 32'h000000ef, 32'(write_out.data));
    check("status hold", 32'h1, 32'(status_hold_out));
    while (!done_out && n++ < 80) @(negedge clk_in);
    check("done", 32'h1, 32'(done_out));
    check("write released", 32'h0, 32'(write_valid_out));
  endtask
  task automatic test_refuse();
    int takes = 0;
    fetch_word_in = 16'h0c31;
    fetch_valid_in = 1'b1;
    repeat (8) begin
      @(negedge clk_in);
      if (fetch_take_out) takes++;
    end
    fetch_valid_in = 1'b0;
    check("refused takes", 32'h0, 32'(takes));
    $display("test_refuse ended");
  endtask
  task automatic test_window();
    store(16'h0009, 32'h00010000, 32'h00010009);
    store(16'h7fff, 32'h00008001, 32'h00010000);
    store(16'h8000, 32'h00018000, 32'h00010000);
    $display("test_window ended");
  endtask
  task automatic test_stall();
    stall = 4'h3;
    store(16'hfffe, 32'h00000001, 32'hffffffff);
    $display("test_stall ended");
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    test_window();
    test_refuse();
    test_stall();
    print_verdict();
  end
  initial begin
    #500000;
    fail_count++;
    print_verdict();
  end
endmodule
